// File: rtl/scmc_pkg.sv
// Constants for the system clock and operating mode controller.
// Assumes an AXI4-Lite master on aclk and oscillator stable inputs from the analog side.
package scmc_pkg;

    localparam logic [3:0] SCMC_OFS_MODE = 4'h0;
    localparam logic [3:0] SCMC_OFS_MISC = 4'h4;

    // system_mode_control fields
    localparam int SCMC_MODE_DIV_LSB = 5;
    localparam int SCMC_MODE_LOW_RDY = 3;
    localparam int SCMC_MODE_HIGH_RDY = 2;
    localparam int SCMC_MODE_IDLE_EN = 1;
    localparam int SCMC_MODE_MAIN_SEL = 0;
    localparam logic [2:0] SCMC_DIV_RST = 3'h0;
    localparam logic SCMC_IDLE_EN_RST = 1'b1;
    localparam logic SCMC_MAIN_SEL_RST = 1'b1;

    // clock_misc_control fields
    localparam int SCMC_MISC_KEEP = 7;
    localparam int SCMC_MISC_FREQ_LSB = 4;
    localparam logic SCMC_KEEP_RST = 1'b0;
    localparam logic [1:0] SCMC_FREQ_RST = 2'h0;

    // Divider field codes; codes below this select the low-speed clock
    localparam logic [2:0] SCMC_DIV_FIRST_HIGH = 3'h2;
    // Divide exponent for code c is DIV_EXP_BASE - c (code 2 -> /64, code 7 -> /2)
    localparam logic [3:0] SCMC_DIV_EXP_BASE = 4'h8;

    // Fast RC frequency trim codes
    localparam logic [1:0] SCMC_FREQ_8MHZ = 2'h0;
    localparam logic [1:0] SCMC_FREQ_16MHZ = 2'h1;
    localparam logic [1:0] SCMC_FREQ_12MHZ = 2'h2;
    localparam logic [1:0] SCMC_FREQ_8MHZ_ALT = 2'h3;

    // Ready flag delays in aclk cycles with the oscillator stable
    localparam int SCMC_LOW_READY_CYCLES = 2;
    localparam int SCMC_HIGH_READY_CYCLES = 16;

    localparam logic [1:0] SCMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCMC_RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SCMC_ST_FAST = 5'h01,
        SCMC_ST_SLOW = 5'h02,
        SCMC_ST_SLEEP = 5'h04,
        SCMC_ST_CLOCK_STOPPED_IDLE = 5'h08,
        SCMC_ST_CLOCK_RUNNING_IDLE = 5'h10
    } scmc_state_t;

endpackage

// File: rtl/scmc_ready_timer.sv
// Oscillator ready flag: counts aclk cycles while the oscillator is stable.
// Assumes stable is synchronous to aclk; restart forces the flag low.
`timescale 1ns/1ps

module scmc_ready_timer #(
    parameter int CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    input wire logic stable,
    output logic ready
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic ready_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || restart || !stable) begin
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            cnt_q <= cnt_q + CW'(1);
            if (cnt_q == LAST) begin
                ready_q <= 1'b1;
            end
        end
    end

    assign ready = ready_q;

endmodule

// File: rtl/scmc_top.sv
// System clock selection and operating mode control with an AXI4-Lite register port.
// Assumes halt_req and wake_req are one-cycle pulses from the core and wake logic,
// and the real clock mux and divider downstream follow the select outputs.
`timescale 1ns/1ps

module scmc_top
    import scmc_pkg::*;
#(
    parameter int LOW_READY_CYCLES = SCMC_LOW_READY_CYCLES,
    parameter int HIGH_READY_CYCLES = SCMC_HIGH_READY_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic low_osc_stable,
    input wire logic high_osc_stable,
    output logic fast_rc_enable,
    output logic [1:0] fast_rc_freq_select,
    output logic sys_clock_high,
    output logic [2:0] sys_clock_div_exp,
    output logic sys_clock_enable,
    output logic cpu_clock_enable,
    output logic low_clock_enable,
    output logic periph_high_clock_enable,
    output logic [4:0] op_mode
);

    // Software-visible control bits
    logic [2:0] clock_divider_select_q;
    logic idle_enable_q;
    logic main_clock_select_q;
    logic idle_clock_keep_q;
    logic [1:0] fast_rc_freq_select_q;

    // Clocking state
    scmc_state_t state_q;
    scmc_state_t state_d;
    logic src_high_q;
    logic src_high_d;
    logic [2:0] div_exp_q;
    logic [2:0] div_exp_d;
    logic fast_rc_enable_q;
    logic fast_rc_enable_d;
    logic sys_clock_enable_q;
    logic cpu_clock_enable_q;
    logic low_clock_enable_q;
    logic periph_high_q;
    logic low_osc_ready;
    logic high_osc_ready;
    logic target_high;
    logic [2:0] target_exp;
    logic running;

    // Bus state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_held_q;
    logic [3:0] aw_addr_q;
    logic w_held_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic do_write;
    logic [7:0] mode_rd;
    logic [7:0] misc_rd;

    // ------------------------------------------------------------------
    // Ready flags
    // ------------------------------------------------------------------

    // Low ready restarts on every wake even though the slow RC never stops
    scmc_ready_timer #(
        .CYCLES(LOW_READY_CYCLES)
    ) u_low_ready (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(wake_req),
        .stable(low_osc_stable),
        .ready(low_osc_ready)
    );

    // High ready drops whenever the fast RC is stopped
    scmc_ready_timer #(
        .CYCLES(HIGH_READY_CYCLES)
    ) u_high_ready (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(!fast_rc_enable_q),
        .stable(high_osc_stable),
        .ready(high_osc_ready)
    );

    // ------------------------------------------------------------------
    // Clock target decode
    // ------------------------------------------------------------------

    assign running = (state_q == SCMC_ST_FAST) || (state_q == SCMC_ST_SLOW);

    always_comb begin
        if (main_clock_select_q) begin
            target_high = 1'b1;
            target_exp = 3'h0;
        end else if (clock_divider_select_q >= SCMC_DIV_FIRST_HIGH) begin
            target_high = 1'b1;
            target_exp = 3'(SCMC_DIV_EXP_BASE - {1'b0, clock_divider_select_q});
        end else begin
            target_high = 1'b0;
            target_exp = 3'h0;
        end
    end

    // ------------------------------------------------------------------
    // Source switching: the old source stays until the new one is ready
    // ------------------------------------------------------------------

    always_comb begin
        src_high_d = src_high_q;
        div_exp_d = div_exp_q;
        if (running) begin
            if (target_high && !src_high_q) begin
                if (high_osc_ready) begin
                    src_high_d = 1'b1;
                    div_exp_d = target_exp;
                end
            end else if (!target_high && src_high_q) begin
                if (low_osc_ready) begin
                    src_high_d = 1'b0;
                    div_exp_d = 3'h0;
                end
            end else if (target_high) begin
                // Divider ratio changes within the fast source apply at once
                div_exp_d = target_exp;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_high_q <= 1'b1;
            div_exp_q <= 3'h0;
        end else begin
            src_high_q <= src_high_d;
            div_exp_q <= div_exp_d;
        end
    end

    // ------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------

    always_comb begin
        state_d = state_q;
        case (state_q)
            SCMC_ST_FAST, SCMC_ST_SLOW: begin
                if (halt_req) begin
                    if (!idle_enable_q) begin
                        state_d = SCMC_ST_SLEEP;
                    end else if (!idle_clock_keep_q) begin
                        state_d = SCMC_ST_CLOCK_STOPPED_IDLE;
                    end else begin
                        state_d = SCMC_ST_CLOCK_RUNNING_IDLE;
                    end
                end else begin
                    state_d = src_high_d ? SCMC_ST_FAST : SCMC_ST_SLOW;
                end
            end
            SCMC_ST_SLEEP, SCMC_ST_CLOCK_STOPPED_IDLE, SCMC_ST_CLOCK_RUNNING_IDLE: begin
                if (wake_req) begin
                    state_d = src_high_q ? SCMC_ST_FAST : SCMC_ST_SLOW;
                end
            end
            default: begin
                state_d = SCMC_ST_FAST;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SCMC_ST_FAST;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Clock enables, all registered; all but the low clock enable from the next state
    // ------------------------------------------------------------------

    always_comb begin
        case (state_d)
            SCMC_ST_FAST, SCMC_ST_SLOW: begin
                // Fast RC starts early when a fast target waits for ready
                fast_rc_enable_d = src_high_d || target_high;
            end
            SCMC_ST_CLOCK_RUNNING_IDLE: begin
                fast_rc_enable_d = src_high_d;
            end
            default: begin
                fast_rc_enable_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_rc_enable_q <= 1'b1;
        end else begin
            fast_rc_enable_q <= fast_rc_enable_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clock_enable_q <= 1'b1;
            sys_clock_enable_q <= 1'b1;
        end else begin
            cpu_clock_enable_q <= (state_d == SCMC_ST_FAST) || (state_d == SCMC_ST_SLOW);
            sys_clock_enable_q <= (state_d == SCMC_ST_FAST) || (state_d == SCMC_ST_SLOW)
                || (state_d == SCMC_ST_CLOCK_RUNNING_IDLE);
        end
    end

    // Watchdog clock source is never gated
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_clock_enable_q <= 1'b1;
        end else begin
            low_clock_enable_q <= 1'b1;
        end
    end

    // Peripheral copies of the fast clock only while the fast RC is up and settled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_high_q <= 1'b0;
        end else begin
            periph_high_q <= fast_rc_enable_d && high_osc_ready && src_high_d;
        end
    end

    // ------------------------------------------------------------------
    // Register write channel
    // ------------------------------------------------------------------

    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end else if (!aw_held_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end else if (!w_held_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= SCMC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_addr_q == SCMC_OFS_MODE || aw_addr_q == SCMC_OFS_MISC)
                ? SCMC_RESP_OKAY : SCMC_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Only writable fields are stored; ready flags and blank bits drop writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_divider_select_q <= SCMC_DIV_RST;
            idle_enable_q <= SCMC_IDLE_EN_RST;
            main_clock_select_q <= SCMC_MAIN_SEL_RST;
        end else if (do_write && w_lane0_q && aw_addr_q == SCMC_OFS_MODE) begin
            clock_divider_select_q <= w_byte_q[SCMC_MODE_DIV_LSB +: 3];
            idle_enable_q <= w_byte_q[SCMC_MODE_IDLE_EN];
            main_clock_select_q <= w_byte_q[SCMC_MODE_MAIN_SEL];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_clock_keep_q <= SCMC_KEEP_RST;
            fast_rc_freq_select_q <= SCMC_FREQ_RST;
        end else if (do_write && w_lane0_q && aw_addr_q == SCMC_OFS_MISC) begin
            idle_clock_keep_q <= w_byte_q[SCMC_MISC_KEEP];
            fast_rc_freq_select_q <= w_byte_q[SCMC_MISC_FREQ_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Register read channel
    // ------------------------------------------------------------------

    always_comb begin
        mode_rd = 8'h00;
        mode_rd[SCMC_MODE_DIV_LSB +: 3] = clock_divider_select_q;
        mode_rd[SCMC_MODE_LOW_RDY] = low_osc_ready;
        mode_rd[SCMC_MODE_HIGH_RDY] = high_osc_ready;
        mode_rd[SCMC_MODE_IDLE_EN] = idle_enable_q;
        mode_rd[SCMC_MODE_MAIN_SEL] = main_clock_select_q;
        misc_rd = 8'h00;
        misc_rd[SCMC_MISC_KEEP] = idle_clock_keep_q;
        misc_rd[SCMC_MISC_FREQ_LSB +: 2] = fast_rc_freq_select_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= SCMC_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            if (s_axi_araddr == SCMC_OFS_MODE) begin
                rdata_q <= {24'h00_0000, mode_rd};
                rresp_q <= SCMC_RESP_OKAY;
            end else if (s_axi_araddr == SCMC_OFS_MISC) begin
                rdata_q <= {24'h00_0000, misc_rd};
                rresp_q <= SCMC_RESP_OKAY;
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= SCMC_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    assign fast_rc_enable = fast_rc_enable_q;
    assign fast_rc_freq_select = fast_rc_freq_select_q;
    assign sys_clock_high = src_high_q;
    assign sys_clock_div_exp = div_exp_q;
    assign sys_clock_enable = sys_clock_enable_q;
    assign cpu_clock_enable = cpu_clock_enable_q;
    assign low_clock_enable = low_clock_enable_q;
    assign periph_high_clock_enable = periph_high_q;
    assign op_mode = state_q;

endmodule

// File: sim/scmc_top_props.sv
// Concurrent checks on the clock select and operating mode outputs of the controller.
// Assumes binding to scmc_top; sees only that module's ports.
`timescale 1ns/1ps

module scmc_top_props
    import scmc_pkg::*;
#(
    parameter int HIGH_READY_CYCLES = SCMC_HIGH_READY_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic halt_req,
    input wire logic fast_rc_enable,
    input wire logic sys_clock_high,
    input wire logic [2:0] sys_clock_div_exp,
    input wire logic sys_clock_enable,
    input wire logic cpu_clock_enable,
    input wire logic low_clock_enable,
    input wire logic periph_high_clock_enable,
    input wire logic [4:0] op_mode
);
    logic running;
    logic [7:0] rc_on_q;

    assign running = (op_mode == SCMC_ST_FAST) || (op_mode == SCMC_ST_SLOW);

    // Saturating count of edges with the fast RC on; a switch must not beat it
    always_ff @(posedge aclk) begin
        if (!aresetn || !fast_rc_enable) begin
            rc_on_q <= 8'h00;
        end else if (rc_on_q != 8'hff) begin
            rc_on_q <= rc_on_q + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_halted;
        halt_req && running;
    endsequence
    sequence s_stopped;
        !cpu_clock_enable && !sys_clock_enable;
    endsequence
    sequence s_to_low;
        $fell(sys_clock_high);
    endsequence

    a_low_clock_on: assert property (low_clock_enable)
        else $error("low clock disabled");
    a_cpu_mode_match: assert property (cpu_clock_enable == running)
        else $error("cpu clock disagrees with mode");
    a_mode_one_hot: assert property ($onehot(op_mode))
        else $error("mode not one-hot");
    a_halt_stops_cpu: assert property (s_halted |=> !running && !cpu_clock_enable)
        else $error("halt did not stop cpu");
    a_sleep_stops: assert property (op_mode == SCMC_ST_SLEEP |-> s_stopped)
        else $error("sleep keeps clocks");
    a_clock_stopped_idle_stops: assert property (op_mode == SCMC_ST_CLOCK_STOPPED_IDLE |-> s_stopped)
        else $error("stopped idle keeps clocks");
    a_clock_running_idle_keeps: assert property (op_mode == SCMC_ST_CLOCK_RUNNING_IDLE |-> sys_clock_enable)
        else $error("running idle lost system clock");
    a_slow_no_high: assert property (op_mode == SCMC_ST_SLOW |->
        !sys_clock_high && !periph_high_clock_enable && sys_clock_div_exp == 3'h0)
        else $error("slow mode offers fast clocks");
    a_fast_rc_stops: assert property (s_to_low |-> ##[0:2] !fast_rc_enable)
        else $error("fast rc left running");
    a_high_waits: assert property ($rose(sys_clock_high) |-> rc_on_q >= HIGH_READY_CYCLES + 1)
        else $error("switched to fast clock before ready");
endmodule

bind scmc_top scmc_top_props #(.HIGH_READY_CYCLES(HIGH_READY_CYCLES)) i_props (.aclk, .aresetn,
    .halt_req, .fast_rc_enable, .sys_clock_high, .sys_clock_div_exp, .sys_clock_enable,
    .cpu_clock_enable, .low_clock_enable, .periph_high_clock_enable, .op_mode);

// File: sim/tb_scmc_top.sv
// Self-checking bench for the clock and mode controller, driven over AXI4-Lite.
// Assumes the checker is bound in; oscillator stable inputs are driven here.
`timescale 1ns/1ps

module tb_scmc_top;
    import scmc_pkg::*;
    localparam int HRC = 16;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
    logic low_osc_stable = 1'b1, high_osc_stable = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, fast_rc_freq_select, rsp;
    logic [31:0] s_axi_rdata, rv;
    logic fast_rc_enable, sys_clock_high, sys_clock_enable, cpu_clock_enable;
    logic low_clock_enable, periph_high_clock_enable;
    logic [2:0] sys_clock_div_exp;
    logic [4:0] op_mode;
    int mismatches = 0;
    int n_compared = 0;

    scmc_top #(.LOW_READY_CYCLES(2), .HIGH_READY_CYCLES(HRC)) i_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .halt_req, .wake_req, .low_osc_stable,
        .high_osc_stable, .fast_rc_enable, .fast_rc_freq_select, .sys_clock_high,
        .sys_clock_div_exp, .sys_clock_enable, .cpu_clock_enable, .low_clock_enable,
        .periph_high_clock_enable, .op_mode);

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wchk(input logic [3:0] a, input logic [31:0] d);
        wr(a, d, 4'hf, rsp);
        check("bresp", 32'(rsp), 32'(SCMC_RESP_OKAY));
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] e);
        rd(a, rv, rsp);
        check("rresp", 32'(rsp), 32'(SCMC_RESP_OKAY));
        check("register read", rv & mask, e);
    endtask

    task automatic pulse(input bit wake);
        @(posedge aclk);
        wake_req <= wake;
        halt_req <= !wake;
        @(posedge aclk);
        wake_req <= 1'b0;
        halt_req <= 1'b0;
    endtask

    // Mode changes may wait on oscillator ready, so the wait is bounded, not fixed
    task automatic wait_mode(input logic [4:0] m);
        int n;
        n = 0;
        while (op_mode !== m && n < 200) begin
            @(posedge aclk);
            n++;
        end
        #1;
        check("op_mode", 32'(op_mode), 32'(m));
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        check("reset mode", 32'(op_mode), 32'(SCMC_ST_FAST));
        check("reset source", 32'(sys_clock_high), 32'h1);
        repeat (HRC + 4) @(posedge aclk);
        rchk(SCMC_OFS_MODE, 32'hffffffff, 32'h0000000f);
        rchk(SCMC_OFS_MISC, 32'hffffffff, 32'h0);
        wchk(SCMC_OFS_MISC, 32'hffffffff);
        rchk(SCMC_OFS_MISC, 32'hffffffff, 32'h000000b0);
        for (int c = 0; c < 4; c++) begin
            wchk(SCMC_OFS_MISC, 32'(c << 4));
            @(posedge aclk);
            #1;
            check("freq select", 32'(fast_rc_freq_select), 32'(c));
        end
        wr(SCMC_OFS_MISC, 32'h80, 4'h0, rsp);
        check("bresp no strobe", 32'(rsp), 32'(SCMC_RESP_OKAY));
        rchk(SCMC_OFS_MISC, 32'hffffffff, 32'h30);
        wr(4'h8, 32'hff, 4'hf, rsp);
        check("bresp unmapped", 32'(rsp), 32'(SCMC_RESP_SLVERR));
        rd(4'h8, rv, rsp);
        check("rresp unmapped", 32'(rsp), 32'(SCMC_RESP_SLVERR));
        check("rdata unmapped", rv, 32'h0);
        for (int c = 2; c < 8; c++) begin
            wchk(SCMC_OFS_MODE, 32'((c << 5) | 2));
            @(posedge aclk);
            #1;
            check("divider", 32'(sys_clock_div_exp), 32'(8 - c));
            check("fast source", 32'(sys_clock_high), 32'h1);
        end
        wchk(SCMC_OFS_MODE, 32'hff);
        @(posedge aclk);
        #1;
        check("undivided", 32'(sys_clock_div_exp), 32'h0);
        rchk(SCMC_OFS_MODE, 32'hffffffff, 32'h000000ef);
        wchk(SCMC_OFS_MODE, 32'h22);
        wait_mode(SCMC_ST_SLOW);
        repeat (3) @(posedge aclk);
        #1;
        check("fast rc off", 32'(fast_rc_enable), 32'h0);
        check("periph fast clocks", 32'(periph_high_clock_enable), 32'h0);
        rchk(SCMC_OFS_MODE, 32'h0000000c, 32'h8);
        wchk(SCMC_OFS_MISC, 32'h80);
        pulse(1'b0);
        wait_mode(SCMC_ST_CLOCK_RUNNING_IDLE);
        check("clock_running_idle sys clock", 32'(sys_clock_enable), 32'h1);
        check("clock_running_idle cpu", 32'(cpu_clock_enable), 32'h0);
        check("clock_running_idle slow source", 32'(sys_clock_high), 32'h0);
        pulse(1'b1);
        wait_mode(SCMC_ST_SLOW);
        wchk(SCMC_OFS_MODE, 32'h03);
        wait_mode(SCMC_ST_FAST);
        rchk(SCMC_OFS_MODE, 32'hffffffff, 32'h0000000f);
        wchk(SCMC_OFS_MISC, 32'h0);
        pulse(1'b0);
        wait_mode(SCMC_ST_CLOCK_STOPPED_IDLE);
        check("clock_stopped_idle sys clock", 32'(sys_clock_enable), 32'h0);
        rchk(SCMC_OFS_MODE, 32'h00000004, 32'h0);
        pulse(1'b1);
        wait_mode(SCMC_ST_FAST);
        repeat (HRC + 4) @(posedge aclk);
        rchk(SCMC_OFS_MODE, 32'h00000004, 32'h4);
        check("periph fast clocks on", 32'(periph_high_clock_enable), 32'h1);
        wchk(SCMC_OFS_MODE, 32'h01);
        low_osc_stable <= 1'b0;
        pulse(1'b0);
        wait_mode(SCMC_ST_SLEEP);
        check("sleep sys clock", 32'(sys_clock_enable), 32'h0);
        check("sleep low clock", 32'(low_clock_enable), 32'h1);
        pulse(1'b1);
        wait_mode(SCMC_ST_FAST);
        rchk(SCMC_OFS_MODE, 32'h00000008, 32'h0);
        @(posedge aclk);
        low_osc_stable <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk(SCMC_OFS_MODE, 32'h00000008, 32'h8);
        wchk(SCMC_OFS_MODE, 32'h02);
        wait_mode(SCMC_ST_SLOW);
        check("code 0 slow source", 32'(sys_clock_high), 32'h0);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        conclude();
    end
endmodule
